// ### include/rri_pkg.sv
// Constants, opcodes, encodings and reset values for the return and
// reset instruction unit.
// Assumes a core clock with four clock edges per instruction cycle.
package rri_pkg;

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 5;
  localparam int BANK_W = 4;
  localparam int UPPER_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int INSTR_W = 16;
  localparam int OFFSET_W = 11;

  // ---------------------------------------------------------------
  // Opcode patterns
  // ---------------------------------------------------------------
  localparam logic [15:0] OPC_SOFT_RESET = 16'h00FF;
  localparam logic [15:0] MASK_RET_INT = 16'hFFFE;
  localparam logic [15:0] OPC_RET_INT = 16'h0010;
  localparam logic [15:0] MASK_RET_LIT = 16'hFF00;
  localparam logic [15:0] OPC_RET_LIT = 16'h0C00;
  localparam logic [15:0] MASK_REL_CALL = 16'hF800;
  localparam logic [15:0] OPC_REL_CALL = 16'hD800;
  localparam int SHADOW_SEL_BIT = 0;
  localparam int OFFSET_SIGN_BIT = 10;

  // ---------------------------------------------------------------
  // Program counter step and reset values
  // ---------------------------------------------------------------
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  localparam logic [20:0] PC_RESET = 21'h00_0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [4:0] UPPER_RESET = 5'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Phases and decoded operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } rri_phase_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SOFT_RESET = 3'b001,
    OP_RET_INT = 3'b010,
    OP_RET_LIT = 3'b011,
    OP_REL_CALL = 3'b100,
    OP_OTHER = 3'b101
  } rri_op_type;

endpackage : rri_pkg

// ### design/rri_return_stack.sv
// Hardware return stack for the return and reset instruction unit.
// Assumes push and pop are never asked in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module rri_return_stack #(
  parameter int DEPTH = rri_pkg::STACK_DEPTH,
  parameter int WIDTH = rri_pkg::PC_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top,
  output logic full,
  output logic empty
);

  localparam int PTR_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic do_push;
  logic do_pop;
  logic [PTR_W-1:0] top_index;

  // ---------------------------------------------------------------
  // Pointer control
  // ---------------------------------------------------------------
  // Full pushes and empty pops leave the stack alone
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign full = (ptr_reg == PTR_FULL);
  assign empty = (ptr_reg == '0);
  assign top_index = empty ? '0 : ptr_reg - PTR_ONE;
  assign top = empty ? '0 : mem[top_index];
  assign ptr_next = clear ? '0 :
                    do_push ? ptr_reg + PTR_ONE :
                    do_pop ? ptr_reg - PTR_ONE : ptr_reg;

  // Pointer register
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // Entry storage, written at the free slot
  always_ff @(posedge clk) begin
    if (do_push && !clear) begin
      mem[ptr_reg] <= push_data;
    end
  end

endmodule : rri_return_stack

`default_nettype wire

// ### design/rri_exec_unit.sv
// Decode and execution of software reset, return from interrupt,
// return with literal and the relative call, with its own Q phases.
// Assumes the fetch logic runs on clk and offers one word per cycle.
//
// Behaviour
// - Word 00FF is the software reset, one cycle, which starts a master_clear style reset.
// - Software reset puts every register and flag held here, except the phase counter, back to its reset value.
// - Word 0010 or 0011 is return_from_interrupt, bit 0 selects shadow restore, and it pops.
// - return_from_interrupt loads the PC from stack_top before the pop.
// - return_from_interrupt sets either the high or low priority global enable.
// - With the select bit at 1 the shadow values go to accumulator, flags and bank_select.
// - With the select bit at 0 accumulator, flags and bank_select stay as they are.
// - Word 0Ckk is return_with_literal: k into the accumulator, PC from stack_top.
// - return_with_literal leaves both PC latches and all flags alone.
// - After a relative_call the PC holds the target and stack_top the call address plus 2.
// - Word D800 to DFFF is relative_call: push PC plus 2, add twice n, two cycles.
`timescale 1ns/10ps
`default_nettype none

module rri_exec_unit #(
  parameter int PC_W = rri_pkg::PC_W,
  parameter int STACK_DEPTH = rri_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [7:0] shadow_accumulator,
  input wire logic [4:0] shadow_flags,
  input wire logic [3:0] shadow_bank_select,
  input wire logic latch_write,
  input wire logic [4:0] latch_upper_data,
  input wire logic [7:0] latch_high_data,
  output logic [PC_W-1:0] program_counter,
  output logic [7:0] accumulator,
  output logic [4:0] flags,
  output logic [3:0] bank_select,
  output logic [4:0] pc_upper_latch,
  output logic [7:0] pc_high_latch,
  output logic high_priority_global_enable,
  output logic low_priority_global_enable,
  output logic [PC_W-1:0] stack_top,
  output logic start_reset,
  output logic [1:0] phase,
  output logic instr_taken,
  output logic busy,
  output logic stack_overflow,
  output logic stack_underflow
);

  // ---------------------------------------------------------------
  // Decode function
  // ---------------------------------------------------------------
  // Classify one instruction word
  function automatic rri_pkg::rri_op_type classify(input logic [15:0] word);
    rri_pkg::rri_op_type op;
    op = rri_pkg::OP_OTHER;
    if (word == rri_pkg::OPC_SOFT_RESET) begin
      op = rri_pkg::OP_SOFT_RESET;
    end else if ((word & rri_pkg::MASK_RET_INT) == rri_pkg::OPC_RET_INT) begin
      op = rri_pkg::OP_RET_INT;
    end else if ((word & rri_pkg::MASK_RET_LIT) == rri_pkg::OPC_RET_LIT) begin
      op = rri_pkg::OP_RET_LIT;
    end else if ((word & rri_pkg::MASK_REL_CALL) == rri_pkg::OPC_REL_CALL) begin
      op = rri_pkg::OP_REL_CALL;
    end
    return op;
  endfunction : classify

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rri_pkg::rri_phase_type q_reg;
  rri_pkg::rri_phase_type q_next;
  rri_pkg::rri_op_type op_reg;
  rri_pkg::rri_op_type op_next;
  rri_pkg::rri_op_type op_decoded;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic second_reg;
  logic second_next;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  logic [3:0] bank_reg;
  logic [3:0] bank_next;
  logic [4:0] upper_reg;
  logic [4:0] upper_next;
  logic [7:0] high_reg;
  logic [7:0] high_next;
  logic gie_high_reg;
  logic gie_high_next;
  logic gie_low_reg;
  logic gie_low_next;
  logic start_reset_reg;
  logic taken_reg;
  logic [PC_W-1:0] top_reg;
  logic overflow_reg;
  logic overflow_next;
  logic underflow_reg;
  logic underflow_next;
  logic at_q1;
  logic at_q2;
  logic at_q4;
  logic take;
  logic soft_go;
  logic call_push;
  logic ret_go;
  logic int_go;
  logic lit_go;
  logic call_go;
  logic plain_go;
  logic cycle2_done;
  logic restore;
  logic [PC_W-1:0] pc_plus_step;
  logic [PC_W-1:0] offset_twice;
  logic [PC_W-1:0] stack_top_w;
  logic stack_full;
  logic stack_empty;

  // ---------------------------------------------------------------
  // Phase and fetch acceptance
  // ---------------------------------------------------------------
  // Phase strobes and acceptance of a word in Q1
  assign at_q1 = (q_reg == rri_pkg::PH_Q1);
  assign at_q2 = (q_reg == rri_pkg::PH_Q2);
  assign at_q4 = (q_reg == rri_pkg::PH_Q4);
  assign q_next = rri_pkg::rri_phase_type'(2'(q_reg + 2'b01));
  assign take = at_q1 & instr_valid & ~second_reg;
  assign op_decoded = classify(instr_word);

  // Decoded operation held through the cycle
  assign op_next = soft_go ? rri_pkg::OP_NONE :
                   at_q1 ? (take ? op_decoded : rri_pkg::OP_NONE) : op_reg;
  assign word_next = soft_go ? '0 : (take ? instr_word : word_reg);

  // ---------------------------------------------------------------
  // Execution strobes
  // ---------------------------------------------------------------
  // One strobe per action, each in Q2 or Q4 of the cycle
  assign soft_go = at_q2 & (op_reg == rri_pkg::OP_SOFT_RESET);
  assign call_push = at_q2 & (op_reg == rri_pkg::OP_REL_CALL);
  assign int_go = at_q4 & (op_reg == rri_pkg::OP_RET_INT);
  assign lit_go = at_q4 & (op_reg == rri_pkg::OP_RET_LIT);
  assign ret_go = int_go | lit_go;
  assign call_go = at_q4 & (op_reg == rri_pkg::OP_REL_CALL);
  assign plain_go = at_q4 & (op_reg == rri_pkg::OP_OTHER);
  assign cycle2_done = at_q4 & second_reg;
  assign restore = int_go & word_reg[rri_pkg::SHADOW_SEL_BIT];

  // Second, idle cycle of the two-cycle instructions
  assign second_next = soft_go ? 1'b0 :
                       (ret_go | call_go) ? 1'b1 :
                       cycle2_done ? 1'b0 : second_reg;

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // Return address and doubled signed offset
  assign pc_plus_step = PC_W'(pc_reg + PC_W'(rri_pkg::PC_STEP));
  assign offset_twice = {{(PC_W - rri_pkg::OFFSET_W - 1){word_reg[rri_pkg::OFFSET_SIGN_BIT]}},
                         word_reg[rri_pkg::OFFSET_W-1:0], 1'b0};

  // Next program counter
  assign pc_next = soft_go ? PC_W'(rri_pkg::PC_RESET) :
                   ret_go ? stack_top_w :
                   call_go ? PC_W'(pc_plus_step + offset_twice) :
                   plain_go ? pc_plus_step : pc_reg;

  // ---------------------------------------------------------------
  // Working and latch registers
  // ---------------------------------------------------------------
  // Accumulator, flags and bank select
  assign acc_next = soft_go ? rri_pkg::ACC_RESET :
                    lit_go ? word_reg[7:0] :
                    restore ? shadow_accumulator : acc_reg;
  assign flags_next = soft_go ? rri_pkg::FLAGS_RESET :
                      restore ? shadow_flags : flags_reg;
  assign bank_next = soft_go ? rri_pkg::BANK_RESET :
                     restore ? shadow_bank_select : bank_reg;

  // PC latches only change by their own write port or a software reset
  assign upper_next = soft_go ? rri_pkg::UPPER_RESET :
                      latch_write ? latch_upper_data : upper_reg;
  assign high_next = soft_go ? rri_pkg::HIGH_RESET :
                     latch_write ? latch_high_data : high_reg;

  // Re-enable: high bit if clear, otherwise the low bit
  assign gie_high_next = soft_go ? 1'b0 :
                         (int_go & ~gie_high_reg) ? 1'b1 : gie_high_reg;
  assign gie_low_next = soft_go ? 1'b0 :
                        (int_go & gie_high_reg) ? 1'b1 : gie_low_reg;

  // Sticky stack faults, a new fault wins over the clear
  assign overflow_next = (call_push & stack_full) | (overflow_reg & ~soft_go);
  assign underflow_next = (ret_go & stack_empty) | (underflow_reg & ~soft_go);

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // Pushed in Q2 of a call, popped in Q4 of a return
  rri_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk(clk),
    .reset(reset),
    .clear(soft_go),
    .push(call_push),
    .pop(ret_go),
    .push_data(pc_plus_step),
    .top(stack_top_w),
    .full(stack_full),
    .empty(stack_empty)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Phase, decode and sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      q_reg <= rri_pkg::PH_Q1;
      op_reg <= rri_pkg::OP_NONE;
      word_reg <= '0;
      second_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      op_reg <= op_next;
      word_reg <= word_next;
      second_reg <= second_next;
    end
  end

  // Program counter and working registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_reg <= PC_W'(rri_pkg::PC_RESET);
      acc_reg <= rri_pkg::ACC_RESET;
      flags_reg <= rri_pkg::FLAGS_RESET;
      bank_reg <= rri_pkg::BANK_RESET;
    end else begin
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      bank_reg <= bank_next;
    end
  end

  // Latches and global enables
  always_ff @(posedge clk) begin
    if (reset) begin
      upper_reg <= rri_pkg::UPPER_RESET;
      high_reg <= rri_pkg::HIGH_RESET;
      gie_high_reg <= 1'b0;
      gie_low_reg <= 1'b0;
    end else begin
      upper_reg <= upper_next;
      high_reg <= high_next;
      gie_high_reg <= gie_high_next;
      gie_low_reg <= gie_low_next;
    end
  end

  // Status outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      start_reset_reg <= 1'b0;
      taken_reg <= 1'b0;
      top_reg <= '0;
      overflow_reg <= 1'b0;
      underflow_reg <= 1'b0;
    end else begin
      start_reset_reg <= soft_go;
      taken_reg <= take;
      top_reg <= stack_top_w;
      overflow_reg <= overflow_next;
      underflow_reg <= underflow_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output straight from a register
  assign program_counter = pc_reg;
  assign accumulator = acc_reg;
  assign flags = flags_reg;
  assign bank_select = bank_reg;
  assign pc_upper_latch = upper_reg;
  assign pc_high_latch = high_reg;
  assign high_priority_global_enable = gie_high_reg;
  assign low_priority_global_enable = gie_low_reg;
  assign stack_top = top_reg;
  assign start_reset = start_reset_reg;
  assign phase = q_reg;
  assign instr_taken = taken_reg;
  assign busy = second_reg;
  assign stack_overflow = overflow_reg;
  assign stack_underflow = underflow_reg;

endmodule : rri_exec_unit

`default_nettype wire

// ### tb/rri_exec_unit_asserts.sv
// Concurrent checks on the ports of the return and reset unit.
// Assumes one clock, synchronous reset, effects four clocks after a take.
`timescale 1ns/10ps
`default_nettype none

module rri_exec_unit_asserts #(
  parameter int PC_W = rri_pkg::PC_W,
  parameter int STACK_DEPTH = rri_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] shadow_accumulator,
  input wire logic [4:0] shadow_flags,
  input wire logic [3:0] shadow_bank_select,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [7:0] accumulator,
  input wire logic [4:0] flags,
  input wire logic [3:0] bank_select,
  input wire logic [4:0] pc_upper_latch,
  input wire logic [7:0] pc_high_latch,
  input wire logic high_priority_global_enable,
  input wire logic low_priority_global_enable,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic start_reset,
  input wire logic instr_taken,
  input wire logic busy
);
  // -------------------------------------------------------------
  // Word decode of the offered instruction
  // -------------------------------------------------------------
  wire logic is_sr = instr_word == rri_pkg::OPC_SOFT_RESET;
  wire logic is_ri = (instr_word & rri_pkg::MASK_RET_INT) == rri_pkg::OPC_RET_INT;
  wire logic is_rl = (instr_word & rri_pkg::MASK_RET_LIT) == rri_pkg::OPC_RET_LIT;
  wire logic is_rc = (instr_word & rri_pkg::MASK_REL_CALL) == rri_pkg::OPC_REL_CALL;
  wire logic is_two = is_ri | is_rl | is_rc;
  wire logic sel = instr_word[0];
  wire logic [7:0] lit = instr_word[7:0];
  wire logic [PC_W-1:0] offs = {{(PC_W-12){instr_word[10]}}, instr_word[10:0], 1'b0};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  property p_reset_start;
    instr_taken && $past(is_sr) |=> start_reset ##1 !start_reset;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("soft reset pulse wrong");

  property p_reset_clears;
    start_reset |-> program_counter == '0 && accumulator == 8'h00 && flags == 5'h00
      && bank_select == 4'h0 && pc_upper_latch == 5'h00 && pc_high_latch == 8'h00
      && !high_priority_global_enable && !low_priority_global_enable;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("soft reset left state");

  property p_ret_int_pc;
    instr_taken && $past(is_ri) |-> ##3 program_counter == $past(stack_top);
  endproperty
  a_ret_int_pc: assert property (p_ret_int_pc) else $error("interrupt return pc wrong");

  property p_ret_int_enable;
    instr_taken && $past(is_ri) |-> ##3 $rose(high_priority_global_enable)
      || $rose(low_priority_global_enable);
  endproperty
  a_ret_int_enable: assert property (p_ret_int_enable) else $error("no enable set");

  property p_shadow_restore;
    instr_taken && $past(is_ri) && $past(sel) |-> ##3 accumulator == $past(shadow_accumulator)
      && flags == $past(shadow_flags) && bank_select == $past(shadow_bank_select);
  endproperty
  a_shadow_restore: assert property (p_shadow_restore) else $error("shadow not restored");

  property p_no_restore;
    instr_taken && $past(is_ri) && !$past(sel) |-> ##3 $stable(accumulator)
      && $stable(flags) && $stable(bank_select);
  endproperty
  a_no_restore: assert property (p_no_restore) else $error("registers changed");

  property p_two_cycle;
    instr_taken && $past(is_two) |-> ##3 busy [*4] ##1 !busy;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("idle cycle wrong");

  property p_ret_lit;
    instr_taken && $past(is_rl) |-> ##3 accumulator == $past(lit, 4)
      && program_counter == $past(stack_top) && $stable(flags)
      && $stable(pc_upper_latch) && $stable(pc_high_latch);
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");

  property p_call;
    instr_taken && $past(is_rc) |-> ##3 stack_top == $past(program_counter, 3) + rri_pkg::PC_STEP
      && program_counter == $past(program_counter, 3) + rri_pkg::PC_STEP + $past(offs, 4);
  endproperty
  a_call: assert property (p_call) else $error("relative call wrong");
endmodule : rri_exec_unit_asserts

bind rri_exec_unit rri_exec_unit_asserts #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) i_asserts (
  .clk(clk), .reset(reset), .instr_word(instr_word), .shadow_accumulator(shadow_accumulator),
  .shadow_flags(shadow_flags), .shadow_bank_select(shadow_bank_select),
  .program_counter(program_counter), .accumulator(accumulator), .flags(flags),
  .bank_select(bank_select), .pc_upper_latch(pc_upper_latch), .pc_high_latch(pc_high_latch),
  .high_priority_global_enable(high_priority_global_enable),
  .low_priority_global_enable(low_priority_global_enable), .stack_top(stack_top),
  .start_reset(start_reset), .instr_taken(instr_taken), .busy(busy)
);

`default_nettype wire

// ### tb/rri_exec_unit_test.sv
// Self-checking bench for the return and reset instruction unit.
// Assumes effects show four clocks after a take, stack_top one more after a return.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end

module rri_exec_unit_test;
  logic clk, reset, instr_valid, latch_write, srst, hen, len, taken, busy, ovf, unf;
  logic [1:0] ph;
  logic [15:0] instr_word;
  logic [7:0] sh_acc, acc, hil_data, hil;
  logic [4:0] sh_flg, flg, upl_data, upl;
  logic [3:0] sh_bnk, bnk;
  logic [20:0] pc, top;
  int error_cnt = 0;
  int total_checks = 0;

  rri_exec_unit i_rri_exec_unit (
    .clk(clk), .reset(reset), .instr_word(instr_word), .instr_valid(instr_valid),
    .shadow_accumulator(sh_acc), .shadow_flags(sh_flg), .shadow_bank_select(sh_bnk),
    .latch_write(latch_write), .latch_upper_data(upl_data), .latch_high_data(hil_data),
    .program_counter(pc), .accumulator(acc), .flags(flg), .bank_select(bnk),
    .pc_upper_latch(upl), .pc_high_latch(hil), .high_priority_global_enable(hen),
    .low_priority_global_enable(len), .stack_top(top), .start_reset(srst), .phase(ph),
    .instr_taken(taken), .busy(busy), .stack_overflow(ovf), .stack_underflow(unf)
  );

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Offer a word until the unit takes it
  task automatic run(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    do begin
      @(negedge clk);
      n++;
    end while (taken !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      finish_test();
    end
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask : run

  task automatic run_settle(input logic [15:0] w);
    run(w);
    repeat (4) @(negedge clk);
  endtask : run_settle

  task automatic expect_core(input logic [20:0] e_pc, input logic [20:0] e_top,
                             input logic [7:0] e_acc, input logic [4:0] e_flg,
                             input logic [3:0] e_bnk);
    `CHK("program_counter", e_pc, pc)
    `CHK("stack_top", e_top, top)
    `CHK("accumulator", e_acc, acc)
    `CHK("flags", e_flg, flg)
    `CHK("bank_select", e_bnk, bnk)
  endtask : expect_core

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_calls();
    run_settle(16'hD805);
    expect_core(21'h00_000C, 21'h00_0002, 8'h00, 5'h00, 4'h0);
    run_settle(16'hDFFF);
    expect_core(21'h00_000C, 21'h00_000E, 8'h00, 5'h00, 4'h0);
  endtask : t_calls

  task automatic t_ret_int_shadow();
    run_settle(16'h0011);
    expect_core(21'h00_000E, 21'h00_0002, 8'h3C, 5'h15, 4'h9);
    `CHK("high_enable", 1'b1, hen)
  endtask : t_ret_int_shadow

  task automatic t_ret_lit();
    @(posedge clk);
    latch_write <= 1'b1;
    upl_data <= 5'h15;
    hil_data <= 8'hAB;
    @(posedge clk);
    latch_write <= 1'b0;
    run_settle(16'h0CA5);
    expect_core(21'h00_0002, 21'h00_0000, 8'hA5, 5'h15, 4'h9);
    `CHK("upper_latch", 5'h15, upl)
    `CHK("high_latch", 8'hAB, hil)
  endtask : t_ret_lit

  task automatic t_ret_int_plain();
    run_settle(16'hD800);
    run_settle(16'h0010);
    expect_core(21'h00_0004, 21'h00_0000, 8'hA5, 5'h15, 4'h9);
    `CHK("low_enable", 1'b1, len)
  endtask : t_ret_int_plain

  // Near miss of the return word, then a return on an empty stack
  task automatic t_faults();
    run_settle(16'h0012);
    expect_core(21'h00_0006, 21'h00_0000, 8'hA5, 5'h15, 4'h9);
    `CHK("enables", 2'h3, {hen, len})
    run_settle(16'h0C00);
    expect_core(21'h00_0000, 21'h00_0000, 8'h00, 5'h15, 4'h9);
    `CHK("stack_underflow", 1'b1, unf)
    `CHK("stack_overflow", 1'b0, ovf)
  endtask : t_faults

  task automatic t_soft_reset();
    run(16'h00FF);
    @(negedge clk);
    `CHK("start_reset", 1'b1, srst)
    `CHK("phase", 2'h2, ph)
    @(negedge clk);
    `CHK("start_reset", 1'b0, srst)
    expect_core(21'h00_0000, 21'h00_0000, 8'h00, 5'h00, 4'h0);
    `CHK("latches", 13'h0000, {upl, hil})
    `CHK("enables", 2'h0, {hen, len})
    `CHK("faults", 2'h0, {ovf, unf})
  endtask : t_soft_reset

  // -------------------------------------------------------------
  // Clock and main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    sh_acc = 8'h3C;
    sh_flg = 5'h15;
    sh_bnk = 4'h9;
    latch_write = 1'b0;
    upl_data = 5'h00;
    hil_data = 8'h00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    expect_core(21'h00_0000, 21'h00_0000, 8'h00, 5'h00, 4'h0);
    `CHK("phase", 2'h0, ph)
    `CHK("faults", 2'h0, {ovf, unf})
    t_calls();
    t_ret_int_shadow();
    t_ret_lit();
    t_ret_int_plain();
    t_faults();
    t_soft_reset();
    finish_test();
  end
endmodule : rri_exec_unit_test

`default_nettype wire
